// File: hdl/plem_consts.svh
`ifndef PLEM_CONSTS_SVH
`define PLEM_CONSTS_SVH
// Register byte offsets on the Avalon-MM slave.
`define PLEM_OFS_CRC_TOTAL 6'h00
`define PLEM_OFS_CRC_WIN 6'h04
`define PLEM_OFS_FS_TOTAL 6'h08
`define PLEM_OFS_FS_WIN 6'h0C
`define PLEM_OFS_CRC_LIMIT 6'h10
`define PLEM_OFS_FS_LIMIT 6'h14
`define PLEM_OFS_LINK_REV 6'h18
`define PLEM_OFS_NET_REV 6'h1C
`define PLEM_OFS_STATUS 6'h20
`define PLEM_OFS_HISTORY 6'h24
`define PLEM_OFS_CONTROL 6'h28
// Reset values of the writable limit registers.
`define PLEM_CRC_LIMIT_RST 16'h000A
`define PLEM_FS_LIMIT_RST 16'h000A
// Control register fields.
`define PLEM_CTL_CLEAR_BIT 0
`define PLEM_CTL_RXEN_BIT 1
// Fault bit positions.
`define PLEM_F_SYNC_LOSS 0
`define PLEM_F_RX_LOSS 1
`define PLEM_F_FS_LIMIT 2
`define PLEM_F_CRC_LIMIT 3
`define PLEM_F_SEQ 4
`define PLEM_F_FORMAT 5
`define PLEM_F_SYSREV 6
`define PLEM_F_DUP_MASTER 7
// Timing: clock in Hz, window in ms, sequence timeout in ms.
`define PLEM_CLK_HZ 50000000
`define PLEM_WINDOW_MS 8
`define PLEM_SEQ_TIMEOUT_MS 1000
`define PLEM_WINDOW_CYCLES ((`PLEM_CLK_HZ / 1000) * `PLEM_WINDOW_MS)
`define PLEM_SEQ_CYCLES ((`PLEM_CLK_HZ / 1000) * `PLEM_SEQ_TIMEOUT_MS)
`endif

// File: hdl/plem_pkg.sv
package plem_pkg;
    // Avalon slave access phases, one-hot.
    typedef enum logic [1:0] {
        PLEM_IDLE = 2'b01,
        PLEM_DONE = 2'b10
    } plem_bus_state_type;
endpackage

// File: hdl/plem_monitor.sv
// Notes on behaviour
// R1 - Count CRC failures cumulatively, readable.
// R2 - Fault clear zeroes both cumulative totals.
// R3 - Report CRC failures of last 8 ms window.
// R4 - Count frame-start errors cumulatively, readable.
// R5 - Report frame-start errors of last window.
// R6 - CRC window count above limit raises event.
// R7 - Frame-start window count above limit raises event.
// R8 - Read-only local link firmware revision.
// R9 - Expose network system revision; majors match.
// R10 - Bit 0: link lost after being established.
// R11 - Bit 1: receive enabled but no data.
// R12 - Bit 2: frame-start errors over limit.
// R13 - Bit 3: CRC errors over limit.
// R14 - Bit 4: sequence mismatch for one second.
// R15 - Bit 5: received format mismatches configuration.
// R16 - Bit 6: received revision differs from local.
// R17 - Bit 7: more than one time master.
// R18 - Status and history words share layout.
// R19 - Latch window counts, restart at boundary.
// R20 - History bits sticky until fault clear.
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "plem_consts.svh"
module plem_monitor #(
    parameter int WINDOW_CYCLES = `PLEM_WINDOW_CYCLES, // Cycles per test window.
    parameter int SEQ_CYCLES = `PLEM_SEQ_CYCLES, // Cycles of sequence mismatch before fault.
    parameter logic [15:0] LINK_REV = 16'h0102 // Arbitrary local firmware revision.
) (
    input wire logic clk, // System clock, 50 MHz.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic [5:0] avs_address, // Byte address.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    input wire logic [3:0] avs_byteenable, // Byte enables.
    output logic [31:0] avs_readdata, // Read data.
    output logic avs_waitrequest, // Wait request.
    input wire logic link_up_pin, // Link established level.
    input wire logic rx_active_pin, // Receive data arriving level.
    input wire logic crc_error_pin, // Toggles once per CRC error.
    input wire logic frame_start_pin, // Toggles once per frame-start error.
    input wire logic seq_match_pin, // Sequence number matches level.
    input wire logic format_mismatch_pin, // Format mismatch level.
    input wire logic [15:0] rx_revision_pin, // Revision carried in received data.
    input wire logic duplicate_time_master_pin, // Second time master seen level.
    output logic [15:0] network_system_revision, // Last received revision.
    output logic crc_limit_event, // One-cycle CRC exception event.
    output logic frame_start_limit_event // One-cycle frame-start exception event.
);
    // Two-stage synchronisers for every pin; stage one is read only by stage two.
    logic [20:0] sync1_reg;
    logic [20:0] sync2_reg;
    logic [20:0] pins;
    assign pins = {rx_revision_pin, link_up_pin, rx_active_pin, crc_error_pin, frame_start_pin,
                   seq_match_pin};
    logic fmt_s1_reg, fmt_s2_reg, dup_s1_reg, dup_s2_reg;

    // Synchronise pins into the clock domain.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_reg <= 21'h000000;
            sync2_reg <= 21'h000000;
            fmt_s1_reg <= 1'b0;
            fmt_s2_reg <= 1'b0;
            dup_s1_reg <= 1'b0;
            dup_s2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            fmt_s1_reg <= format_mismatch_pin;
            fmt_s2_reg <= fmt_s1_reg;
            dup_s1_reg <= duplicate_time_master_pin;
            dup_s2_reg <= dup_s1_reg;
        end
    end

    // The revision word has no handshake, so the peer must hold it steady while data arrives.
    logic [15:0] rx_rev;
    logic link_up, rx_active, crc_lvl, fs_lvl, seq_match;
    assign rx_rev = sync2_reg[20:5];
    assign link_up = sync2_reg[4];
    assign rx_active = sync2_reg[3];
    assign crc_lvl = sync2_reg[2];
    assign fs_lvl = sync2_reg[1];
    assign seq_match = sync2_reg[0];

    // Toggle edges become error pulses; toggling avoids losing back-to-back errors.
    logic crc_prev_reg, fs_prev_reg;
    logic crc_pulse, fs_pulse;
    assign crc_pulse = crc_lvl ^ crc_prev_reg;
    assign fs_pulse = fs_lvl ^ fs_prev_reg;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crc_prev_reg <= 1'b0;
            fs_prev_reg <= 1'b0;
        end
        else
        begin
            crc_prev_reg <= crc_lvl;
            fs_prev_reg <= fs_lvl;
        end
    end

    // Software registers.
    logic [15:0] crc_error_limit_reg; // CRC limit per window.
    logic [15:0] frame_start_error_limit_reg; // Frame-start limit per window.
    logic rx_enable_reg; // Receive port configured to receive.
    logic clear_pulse_reg; // One-cycle fault clear request.

    // Saturating increment, shared by all error counters.
    function automatic logic [31:0] plem_inc(input logic [31:0] v);
        plem_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h00000001;
    endfunction

    // Cumulative totals.
    logic [31:0] crc_error_total_reg;
    logic [31:0] frame_start_error_total_reg;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crc_error_total_reg <= 32'h00000000;
            frame_start_error_total_reg <= 32'h00000000;
        end
        else if (clear_pulse_reg)
        begin
            // An error in the clear cycle still counts, so it is not lost.
            crc_error_total_reg <= {31'h00000000, crc_pulse}; // [R2]
            frame_start_error_total_reg <= {31'h00000000, fs_pulse}; // [R2]
        end
        else
        begin
            if (crc_pulse)
                crc_error_total_reg <= plem_inc(crc_error_total_reg); // [R1]
            if (fs_pulse)
                frame_start_error_total_reg <= plem_inc(frame_start_error_total_reg); // [R4]
        end
    end

    // Window timer and running window counts.
    logic [31:0] win_timer_reg;
    logic win_end;
    logic [31:0] crc_run_reg, fs_run_reg;
    logic [31:0] crc_error_window_count_reg, frame_start_error_window_count_reg;
    logic [31:0] crc_final, fs_final;
    assign win_end = (win_timer_reg == 32'(WINDOW_CYCLES - 1));
    assign crc_final = crc_pulse ? plem_inc(crc_run_reg) : crc_run_reg;
    assign fs_final = fs_pulse ? plem_inc(fs_run_reg) : fs_run_reg;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            win_timer_reg <= 32'h00000000;
        else if (win_end)
            win_timer_reg <= 32'h00000000;
        else
            win_timer_reg <= win_timer_reg + 32'h00000001;
    end

    // Latch the counts at each boundary and restart from zero.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crc_run_reg <= 32'h00000000;
            fs_run_reg <= 32'h00000000;
            crc_error_window_count_reg <= 32'h00000000;
            frame_start_error_window_count_reg <= 32'h00000000;
        end
        else if (win_end)
        begin
            crc_error_window_count_reg <= crc_final; // [R3] [R19]
            frame_start_error_window_count_reg <= fs_final; // [R5] [R19]
            crc_run_reg <= 32'h00000000; // [R19]
            fs_run_reg <= 32'h00000000; // [R19]
        end
        else
        begin
            crc_run_reg <= crc_final;
            fs_run_reg <= fs_final;
        end
    end

    // Limit checks at the boundary; the event pulses and the fault level holds one window.
    logic crc_over_reg, fs_over_reg;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crc_limit_event <= 1'b0;
            frame_start_limit_event <= 1'b0;
            crc_over_reg <= 1'b0;
            fs_over_reg <= 1'b0;
        end
        else
        begin
            crc_limit_event <= win_end && (crc_final > {16'h0000, crc_error_limit_reg}); // [R6]
            frame_start_limit_event <= win_end && (fs_final > {16'h0000, frame_start_error_limit_reg}); // [R7]
            if (win_end)
            begin
                crc_over_reg <= crc_final > {16'h0000, crc_error_limit_reg}; // [R13]
                fs_over_reg <= fs_final > {16'h0000, frame_start_error_limit_reg}; // [R12]
            end
        end
    end

    // Link history and sequence timeout.
    logic was_up_reg;
    logic [31:0] seq_timer_reg;
    logic seq_fault;
    assign seq_fault = (seq_timer_reg >= 32'(SEQ_CYCLES));
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            was_up_reg <= 1'b0;
            seq_timer_reg <= 32'h00000000;
        end
        else
        begin
            // Loss is reported only once the link has been up.
            if (link_up)
                was_up_reg <= 1'b1;
            else if (clear_pulse_reg)
                was_up_reg <= 1'b0;
            if (seq_match)
                seq_timer_reg <= 32'h00000000;
            else if (!seq_fault)
                seq_timer_reg <= seq_timer_reg + 32'h00000001; // [R14]
        end
    end

    // Network revision as last received.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            network_system_revision <= 16'h0000;
        else if (rx_active)
            network_system_revision <= rx_rev; // [R9]
    end

    // Current fault word and sticky history with the same layout.
    logic [7:0] link_fault_status_reg;
    logic [7:0] link_fault_history_reg;
    logic [7:0] fault_now;
    always_comb
    begin
        fault_now = 8'h00;
        fault_now[`PLEM_F_SYNC_LOSS] = was_up_reg && !link_up; // [R10]
        fault_now[`PLEM_F_RX_LOSS] = rx_enable_reg && !rx_active; // [R11]
        fault_now[`PLEM_F_FS_LIMIT] = fs_over_reg; // [R12]
        fault_now[`PLEM_F_CRC_LIMIT] = crc_over_reg; // [R13]
        fault_now[`PLEM_F_SEQ] = seq_fault; // [R14]
        fault_now[`PLEM_F_FORMAT] = rx_enable_reg && fmt_s2_reg; // [R15]
        fault_now[`PLEM_F_SYSREV] = rx_active && (rx_rev != LINK_REV); // [R16]
        fault_now[`PLEM_F_DUP_MASTER] = dup_s2_reg; // [R17]
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link_fault_status_reg <= 8'h00;
            link_fault_history_reg <= 8'h00;
        end
        else
        begin
            link_fault_status_reg <= fault_now; // [R18]
            // Set wins over clear so a fault in the clear cycle is kept.
            if (clear_pulse_reg)
                link_fault_history_reg <= fault_now; // [R20]
            else
                link_fault_history_reg <= link_fault_history_reg | fault_now; // [R18] [R20]
        end
    end

    // Avalon slave: one wait cycle, answer in the second cycle of a request.
    plem_pkg::plem_bus_state_type bus_state_reg;
    logic [31:0] rd_mux;
    always_comb
    begin
        case (avs_address)
            `PLEM_OFS_CRC_TOTAL: rd_mux = crc_error_total_reg; // [R1]
            `PLEM_OFS_CRC_WIN: rd_mux = crc_error_window_count_reg; // [R3]
            `PLEM_OFS_FS_TOTAL: rd_mux = frame_start_error_total_reg; // [R4]
            `PLEM_OFS_FS_WIN: rd_mux = frame_start_error_window_count_reg; // [R5]
            `PLEM_OFS_CRC_LIMIT: rd_mux = {16'h0000, crc_error_limit_reg};
            `PLEM_OFS_FS_LIMIT: rd_mux = {16'h0000, frame_start_error_limit_reg};
            `PLEM_OFS_LINK_REV: rd_mux = {16'h0000, LINK_REV}; // [R8]
            `PLEM_OFS_NET_REV: rd_mux = {16'h0000, network_system_revision}; // [R9]
            `PLEM_OFS_STATUS: rd_mux = {24'h000000, link_fault_status_reg}; // [R18]
            `PLEM_OFS_HISTORY: rd_mux = {24'h000000, link_fault_history_reg}; // [R18]
            `PLEM_OFS_CONTROL: rd_mux = {30'h00000000, rx_enable_reg, 1'b0};
            default: rd_mux = 32'h00000000; // Unmapped reads as zero.
        endcase
    end

    // Access sequencing and read data capture.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_state_reg <= plem_pkg::PLEM_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            case (bus_state_reg)
                plem_pkg::PLEM_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        bus_state_reg <= plem_pkg::PLEM_DONE;
                        avs_waitrequest <= 1'b0;
                        // A write answer leaves the last read data in place for software.
                        if (avs_read)
                            avs_readdata <= rd_mux;
                    end
                end
                plem_pkg::PLEM_DONE:
                begin
                    bus_state_reg <= plem_pkg::PLEM_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    bus_state_reg <= plem_pkg::PLEM_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Register writes take effect at the edge where waitrequest is seen low.
    logic wr_take;
    assign wr_take = avs_write && (bus_state_reg == plem_pkg::PLEM_DONE);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crc_error_limit_reg <= `PLEM_CRC_LIMIT_RST;
            frame_start_error_limit_reg <= `PLEM_FS_LIMIT_RST;
            rx_enable_reg <= 1'b0;
            clear_pulse_reg <= 1'b0;
        end
        else
        begin
            clear_pulse_reg <= 1'b0;
            if (wr_take && avs_address == `PLEM_OFS_CRC_LIMIT)
            begin
                if (avs_byteenable[0]) crc_error_limit_reg[7:0] <= avs_writedata[7:0]; // [R6]
                if (avs_byteenable[1]) crc_error_limit_reg[15:8] <= avs_writedata[15:8]; // [R6]
            end
            if (wr_take && avs_address == `PLEM_OFS_FS_LIMIT)
            begin
                if (avs_byteenable[0]) frame_start_error_limit_reg[7:0] <= avs_writedata[7:0]; // [R7]
                if (avs_byteenable[1]) frame_start_error_limit_reg[15:8] <= avs_writedata[15:8]; // [R7]
            end
            if (wr_take && avs_address == `PLEM_OFS_CONTROL && avs_byteenable[0])
            begin
                rx_enable_reg <= avs_writedata[`PLEM_CTL_RXEN_BIT];
                clear_pulse_reg <= avs_writedata[`PLEM_CTL_CLEAR_BIT]; // [R2] [R20]
            end
        end
    end
endmodule

// File: dv/plem_monitor_chk.sv
`timescale 1ns/1ps
// Watches the bus handshake, the limit events and the revision output.
module plem_monitor_chk (
    input wire logic clk, // Clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_readdata, // Read data.
    input wire logic avs_waitrequest, // Wait request.
    input wire logic rx_active_pin, // Data arriving.
    input wire logic [15:0] rx_revision_pin, // Received revision.
    input wire logic [15:0] network_system_revision, // Reported revision.
    input wire logic crc_limit_event, // CRC event.
    input wire logic frame_start_limit_event // Frame-start event.
);
    // One clock domain, so one clocking and one disable serve all.
    default clocking main_cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Software must get every count back, so a taken request is answered quickly.
    bus_answer_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("Bus request was not answered.");
    answer_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Answer lasted more than one cycle.");
    answer_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("Answer without a request.");
    // Read data may only move on a read answer, or a stale count could be seen.
    rdata_hold_a: assert property (!$stable(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
        else $error("Read data changed outside a read answer.");
    crc_pulse_a: assert property (crc_limit_event |=> !crc_limit_event)
        else $error("CRC event is not a single pulse.");
    fs_pulse_a: assert property (frame_start_limit_event |=> !frame_start_limit_event)
        else $error("Frame-start event is not a single pulse.");
    // Five steady cycles cover the synchroniser and the output register.
    rev_follow_a: assert property (
        (rx_active_pin && $stable(rx_revision_pin)) [*5] |-> network_system_revision == rx_revision_pin)
        else $error("Network revision does not follow the received one.");
    rev_hold_a: assert property ((!rx_active_pin) [*5] |=> $stable(network_system_revision))
        else $error("Network revision moved with no data arriving.");
endmodule
bind plem_monitor plem_monitor_chk chk_u (.clk(clk), .arst_n(arst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_active_pin(rx_active_pin), .rx_revision_pin(rx_revision_pin),
    .network_system_revision(network_system_revision), .crc_limit_event(crc_limit_event),
    .frame_start_limit_event(frame_start_limit_event));

// File: dv/plem_peer_model.sv
`timescale 1ns/1ps
// A far node of the link, reduced to the pins the monitor watches.
module plem_peer_model (
    input wire logic clk, // Bench clock.
    output logic link_up_pin = 1'b0, // Link up.
    output logic rx_active_pin = 1'b0, // Data arriving.
    output logic crc_error_pin = 1'b0, // CRC error toggle.
    output logic frame_start_pin = 1'b0, // Frame-start error toggle.
    output logic seq_match_pin = 1'b1, // Sequence matches.
    output logic format_mismatch_pin = 1'b0, // Format differs.
    output logic [15:0] rx_revision_pin = 16'hFEFD, // No frames yet, so no valid revision.
    output logic duplicate_time_master_pin = 1'b0 // Second time master.
);
    // Each error is one toggle held two cycles, so the synchroniser cannot miss it.
    task automatic inject(input int crc_n, input int fs_n);
        for (int i = 0; i < crc_n || i < fs_n; i++)
        begin
            @(posedge clk);
            if (i < crc_n)
                crc_error_pin <= ~crc_error_pin;
            if (i < fs_n)
                frame_start_pin <= ~frame_start_pin;
            @(posedge clk);
        end
    endtask
    // With no frames the revision lines carry garbage, but only once reception has stopped.
    task automatic set_levels(input logic lu, ra, sm, fm, input logic [15:0] rv, input logic dm);
        @(posedge clk);
        link_up_pin <= lu;
        rx_active_pin <= ra;
        seq_match_pin <= sm;
        format_mismatch_pin <= fm;
        duplicate_time_master_pin <= dm;
        if (ra)
            rx_revision_pin <= rv;
        else
        begin
            repeat (4) @(posedge clk);
            rx_revision_pin <= ~rv;
        end
    endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
// Register-level bench: the peer makes the faults, the bus tasks read the results.
module testbench;
    localparam int WIN = 50; // A short window keeps the run brief.
    logic clk, avs_waitrequest, crc_limit_event, frame_start_limit_event; // Clock and outputs.
    logic arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0; // Reset and bus strobes.
    logic [5:0] avs_address = 6'h00; // Bus address.
    logic [31:0] avs_writedata = 32'h0, avs_readdata; // Bus data.
    logic link_up_pin, rx_active_pin, crc_error_pin, frame_start_pin; // Peer pins.
    logic seq_match_pin, format_mismatch_pin, duplicate_time_master_pin; // Peer pins.
    logic [15:0] rx_revision_pin, network_system_revision; // Revisions.
    int fail_count = 0, comparisons = 0, crc_ev = 0, fs_ev = 0; // Scores and event tallies.
    plem_monitor #(.WINDOW_CYCLES(WIN), .SEQ_CYCLES(100)) dut_u (.clk(clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link_up_pin(link_up_pin), .rx_active_pin(rx_active_pin),
        .crc_error_pin(crc_error_pin), .frame_start_pin(frame_start_pin), .seq_match_pin(seq_match_pin),
        .format_mismatch_pin(format_mismatch_pin), .rx_revision_pin(rx_revision_pin),
        .duplicate_time_master_pin(duplicate_time_master_pin),
        .network_system_revision(network_system_revision), .crc_limit_event(crc_limit_event),
        .frame_start_limit_event(frame_start_limit_event));
    plem_peer_model peer_u (.clk(clk), .link_up_pin(link_up_pin), .rx_active_pin(rx_active_pin),
        .crc_error_pin(crc_error_pin), .frame_start_pin(frame_start_pin), .seq_match_pin(seq_match_pin),
        .format_mismatch_pin(format_mismatch_pin), .rx_revision_pin(rx_revision_pin),
        .duplicate_time_master_pin(duplicate_time_master_pin));
    // 50 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Event pulses last one cycle, so they are tallied between edges.
    always @(negedge clk)
    begin
        if (crc_limit_event === 1'b1)
            crc_ev <= crc_ev + 1;
        if (frame_start_limit_event === 1'b1)
            fs_ev <= fs_ev + 1;
    end
    // Register value compare; four-state, so an unknown never matches.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    // Count compare for tallies kept by the bench.
    task automatic chk_n(input int got, input int exp);
        comparisons++;
        if (got != exp)
        begin
            fail_count++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    // One access; an edge passes first, so a strobe is never dropped and raised in one step.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        // Sample on rising edges only; the watchdog is the one limit on a stuck slave.
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        // One wait cycle, so the answer is seen at the second edge after the request.
        chk_n(n, 2);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    // Waits, bounded, for the next CRC limit event.
    task automatic wait_crc;
        int n, c;
        c = crc_ev;
        for (n = 0; n < 3 * WIN && crc_ev == c; n++)
            @(negedge clk);
        chk_n(crc_ev, c + 1);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // The whole run needs well under a thousand cycles.
    initial
    begin
        repeat (4000) @(posedge clk);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test;
    end
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        rd(6'h10, 32'h0000_000A);
        rd(6'h14, 32'h0000_000A);
        rd(6'h00, 32'h0);
        rd(6'h24, 32'h0);
        wr(6'h18, 32'hFFFF_FFFF);
        rd(6'h18, 32'h0000_0102);
        rd(6'h2C, 32'h0);
        $display("test reset_values done");
        // A lone error marks a window end; later bursts then sit well inside one window.
        wr(6'h10, 32'h0);
        wr(6'h14, 32'h0);
        peer_u.inject(1, 1);
        wait_crc;
        chk_n(fs_ev, 1);
        wr(6'h10, 32'h2);
        wr(6'h14, 32'h3);
        peer_u.inject(3, 3);
        wait_crc;
        chk_n(fs_ev, 1);
        rd(6'h04, 32'h3);
        rd(6'h0C, 32'h3);
        rd(6'h00, 32'h4);
        rd(6'h08, 32'h4);
        rd(6'h20, 32'h08);
        rd(6'h24, 32'h0C);
        $display("test error_windows done");
        wr(6'h28, 32'h2);
        peer_u.set_levels(1'b1, 1'b0, 1'b1, 1'b0, 16'h0102, 1'b0);
        repeat (5) @(posedge clk);
        peer_u.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 16'h0102, 1'b0);
        repeat (130) @(posedge clk);
        rd(6'h20, 32'h13);
        peer_u.set_levels(1'b1, 1'b1, 1'b1, 1'b1, 16'h0203, 1'b1);
        repeat (10) @(posedge clk);
        rd(6'h20, 32'hE0);
        rd(6'h1C, 32'h0203);
        rd(6'h24, 32'hFF);
        $display("test fault_bits done");
        wr(6'h28, 32'h3);
        rd(6'h00, 32'h0);
        rd(6'h08, 32'h0);
        rd(6'h24, 32'hE0);
        rd(6'h28, 32'h2);
        peer_u.set_levels(1'b1, 1'b1, 1'b1, 1'b0, 16'h0102, 1'b0);
        repeat (10) @(posedge clk);
        rd(6'h20, 32'h0);
        rd(6'h24, 32'hE0);
        $display("test fault_clear done");
        end_of_test;
    end
endmodule
